// ---- rtl/arith_stack_datapath.sv ----
// accumulator exchange, stack save/restore and arithmetic datapath.
// assumes a synchronous data memory that returns rdata the cycle after mem_rd.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "arith_stack_consts.svh"
`default_nettype none
module arith_stack_datapath
  import arith_stack_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // data memory
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_rd,
  output logic mem_wr,
  input wire logic [7:0] mem_rdata
);
  state_s s_q;
  state_s s_d;

  // ==========================================================
  // helpers
  // returns {overflow, aux carry, carry, zero, result}; subtract reports borrows
  function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin, input logic sub);
    logic [8:0] s9;
    logic [4:0] h5;
    logic sgn_ovf;
    s9 = 9'h000;
    h5 = 5'h00;
    sgn_ovf = 1'b0;
    if (sub) begin
      s9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
      h5 = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
      sgn_ovf = (a[7] != b[7]) && (s9[7] != a[7]);
    end else begin
      s9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      h5 = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      sgn_ovf = (a[7] == b[7]) && (s9[7] != a[7]);
    end
    return {sgn_ovf, h5[4], s9[8], (s9[7:0] == 8'h00), s9[7:0]};
  endfunction

  function automatic logic needs_read(input op_e op);
    case (op)
      OP_SAVE, OP_RESTORE, OP_ADD_AI, OP_SUB_AI, OP_ADDC_A, OP_SUBC_A, OP_CLEAR_M: begin
        return 1'b0;
      end
      default: begin
        return 1'b1;
      end
    endcase
  endfunction

  function automatic logic [33:0] reg_read(input logic [31:0] addr, input state_s s);
    case (addr)
      `ADDR_CMD: return {`RESP_OKAY, 8'h00, s.imm, s.maddr, 3'h0, s.op};
      `ADDR_WORK: return {`RESP_OKAY, 24'h00_0000, s.work_register};
      `ADDR_FLAGS: return {`RESP_OKAY, 28'h000_0000, s.flags};
      `ADDR_STACK: return {`RESP_OKAY, 24'h00_0000, s.stack_pointer};
      `ADDR_STATUS: return {`RESP_OKAY, 31'h0000_0000, (s.state != S_IDLE)};
      default: return {`RESP_SLVERR, 32'h0000_0000};
    endcase
  endfunction

  // ==========================================================
  // bus decode
  logic do_wr;
  logic wr_mapped;
  logic idle;
  logic cmd_start;
  op_e cmd_op;
  assign idle = (s_q.state == S_IDLE);
  assign do_wr = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign wr_mapped = (s_q.awaddr == `ADDR_CMD) || (s_q.awaddr == `ADDR_WORK) ||
                     (s_q.awaddr == `ADDR_FLAGS) || (s_q.awaddr == `ADDR_STACK) ||
                     (s_q.awaddr == `ADDR_STATUS);
  assign cmd_op = op_e'(s_q.wdata[`CMD_OP_MSB:`CMD_OP_LSB]);
  // a command is only taken when idle, with the low three byte strobes set and a known code
  assign cmd_start = do_wr && idle && (s_q.awaddr == `ADDR_CMD) &&
                     (s_q.wstrb[2:0] == 3'h7) && (s_q.wdata[4:0] <= `OP_LAST);

  // ==========================================================
  // operand selection
  logic [7:0] op_a;
  logic [7:0] op_b;
  logic op_cin;
  logic op_sub;
  logic op_to_mem;
  logic [11:0] alu_out;
  always_comb begin
    op_a = s_q.work_register;
    op_b = mem_rdata;
    op_cin = 1'b0;
    op_sub = 1'b0;
    op_to_mem = 1'b0;
    case (s_q.op)
      OP_ADD_AI: op_b = s_q.imm;
      OP_ADD_AM: op_b = mem_rdata;
      OP_ADD_MA: op_to_mem = 1'b1;
      OP_ADDC_AM: op_cin = s_q.flags.c;
      OP_ADDC_MA: begin
        op_cin = s_q.flags.c;
        op_to_mem = 1'b1;
      end
      OP_ADDC_A: begin
        op_b = 8'h00;
        op_cin = s_q.flags.c;
      end
      OP_ADDC_M: begin
        op_a = mem_rdata;
        op_b = 8'h00;
        op_cin = s_q.flags.c;
        op_to_mem = 1'b1;
      end
      OP_NADD_AM: begin
        op_a = mem_rdata;
        op_b = s_q.work_register;
        op_sub = 1'b1;
      end
      OP_NADD_MA: begin
        op_sub = 1'b1;
        op_to_mem = 1'b1;
      end
      OP_SUB_AI: begin
        op_b = s_q.imm;
        op_sub = 1'b1;
      end
      OP_SUB_AM: op_sub = 1'b1;
      OP_SUB_MA: begin
        op_a = mem_rdata;
        op_b = s_q.work_register;
        op_sub = 1'b1;
        op_to_mem = 1'b1;
      end
      OP_SUBC_AM: begin
        op_cin = s_q.flags.c;
        op_sub = 1'b1;
      end
      OP_SUBC_MA: begin
        op_a = mem_rdata;
        op_b = s_q.work_register;
        op_cin = s_q.flags.c;
        op_sub = 1'b1;
        op_to_mem = 1'b1;
      end
      OP_SUBC_A: begin
        op_b = 8'h00;
        op_cin = s_q.flags.c;
        op_sub = 1'b1;
      end
      OP_SUBC_M: begin
        op_a = mem_rdata;
        op_b = 8'h00;
        op_cin = s_q.flags.c;
        op_sub = 1'b1;
        op_to_mem = 1'b1;
      end
      OP_INC_M: begin
        op_a = mem_rdata;
        op_b = 8'h01;
        op_to_mem = 1'b1;
      end
      OP_DEC_M: begin
        op_a = mem_rdata;
        op_b = 8'h01;
        op_sub = 1'b1;
        op_to_mem = 1'b1;
      end
      default: op_to_mem = 1'b0;
    endcase
    alu_out = alu(op_a, op_b, op_cin, op_sub);
  end

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.mem_rd = 1'b0;
    s_d.mem_wr = 1'b0;
    if (awvalid && awready) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_held = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // register writes land only while idle so they never race the sequencer
    if (do_wr) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      if (idle && s_q.wstrb[0]) begin
        case (s_q.awaddr)
          `ADDR_WORK: s_d.work_register = s_q.wdata[7:0];
          `ADDR_FLAGS: s_d.flags = s_q.wdata[3:0];
          `ADDR_STACK: s_d.stack_pointer = s_q.wdata[7:0];
          default: s_d.flags = s_q.flags;
        endcase
      end
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      {s_d.rresp, s_d.rdata} = reg_read(araddr, s_q);
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    case (s_q.state)
      S_IDLE: begin
        if (cmd_start) begin
          s_d.op = cmd_op;
          s_d.maddr = s_q.wdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
          s_d.imm = s_q.wdata[`CMD_IMM_MSB:`CMD_IMM_LSB];
          if (cmd_op == OP_RESTORE) begin
            s_d.stack_pointer = s_q.stack_pointer - `STACK_STEP;
            s_d.mem_addr = s_q.stack_pointer - `STACK_STEP;
            s_d.mem_rd = 1'b1;
            s_d.state = S_WAIT;
          end else if (needs_read(cmd_op)) begin
            s_d.mem_addr = s_q.wdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
            s_d.mem_rd = 1'b1;
            s_d.state = S_WAIT;
          end else begin
            s_d.state = S_EXEC;
          end
        end
      end
      S_WAIT: s_d.state = S_EXEC;
      S_EXEC: begin
        s_d.state = S_IDLE;
        case (s_q.op)
          OP_SWAP: begin
            s_d.mem_addr = s_q.maddr;
            s_d.mem_wdata = s_q.work_register;
            s_d.mem_wr = 1'b1;
            s_d.work_register = mem_rdata;
          end
          OP_SAVE: begin
            s_d.mem_addr = s_q.stack_pointer;
            s_d.mem_wdata = s_q.work_register;
            s_d.mem_wr = 1'b1;
            s_d.state = S_PUSH_HI;
          end
          OP_RESTORE: begin
            s_d.work_register = mem_rdata;
            s_d.mem_addr = s_q.stack_pointer + 8'h01;
            s_d.mem_rd = 1'b1;
            s_d.state = S_POP_WAIT;
          end
          OP_CLEAR_M: begin
            s_d.mem_addr = s_q.maddr;
            s_d.mem_wdata = 8'h00;
            s_d.mem_wr = 1'b1;
          end
          default: begin
            s_d.flags = alu_out[11:8];
            if (op_to_mem) begin
              s_d.mem_addr = s_q.maddr;
              s_d.mem_wdata = alu_out[7:0];
              s_d.mem_wr = 1'b1;
            end else begin
              s_d.work_register = alu_out[7:0];
            end
          end
        endcase
      end
      S_PUSH_HI: begin
        s_d.mem_addr = s_q.stack_pointer + 8'h01;
        s_d.mem_wdata = {4'h0, s_q.flags};
        s_d.mem_wr = 1'b1;
        s_d.stack_pointer = s_q.stack_pointer + `STACK_STEP;
        s_d.state = S_IDLE;
      end
      S_POP_WAIT: s_d.state = S_POP_HI;
      S_POP_HI: begin
        s_d.flags = mem_rdata[3:0];
        s_d.state = S_IDLE;
      end
      default: s_d.state = S_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.state <= S_IDLE;
      s_q.work_register <= `RST_WORK;
      s_q.flags <= `RST_FLAGS;
      s_q.stack_pointer <= `RST_STACK;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs
  assign awready = !s_q.aw_held;
  assign wready = !s_q.w_held;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign mem_addr = s_q.mem_addr;
  assign mem_wdata = s_q.mem_wdata;
  assign mem_rd = s_q.mem_rd;
  assign mem_wr = s_q.mem_wr;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  swap_data_a: assert property ((s_q.state == S_EXEC && s_q.op == OP_SWAP) |=>
    mem_wr && mem_wdata == $past(s_q.work_register) &&
    s_q.work_register == $past(mem_rdata) && $stable(s_q.flags))
    else $error("exchange did not swap cleanly");
  push_step_a: assert property ((s_q.state == S_PUSH_HI) |=>
    s_q.stack_pointer == $past(s_q.stack_pointer) + 8'h02 && $stable(s_q.flags))
    else $error("save did not advance stack pointer by two");
  push_order_a: assert property ((s_q.state == S_EXEC && s_q.op == OP_SAVE) |=>
    mem_wr && mem_addr == s_q.stack_pointer ##1
    mem_wr && mem_addr == $past(s_q.stack_pointer, 2) + 8'h01)
    else $error("save byte order wrong");
  pop_lower_a: assert property ((cmd_start && cmd_op == OP_RESTORE) |=>
    mem_rd && mem_addr == $past(s_q.stack_pointer) - 8'h02 ##1 !mem_rd ##1
    mem_rd && mem_addr == $past(s_q.stack_pointer, 3) - 8'h01)
    else $error("restore addressing wrong");
  add_imm_a: assert property ((s_q.state == S_EXEC && s_q.op == OP_ADD_AI) |=>
    s_q.work_register == $past(s_q.work_register) + $past(s_q.imm))
    else $error("add immediate result wrong");
  inc_mem_a: assert property ((s_q.state == S_EXEC && s_q.op == OP_INC_M) |=>
    mem_wr && mem_wdata == $past(mem_rdata) + 8'h01 && s_q.flags.z == (mem_wdata == 8'h00))
    else $error("increment result wrong");
  dec_mem_a: assert property ((s_q.state == S_EXEC && s_q.op == OP_DEC_M) |=>
    mem_wr && mem_wdata == $past(mem_rdata) - 8'h01 &&
    s_q.flags.c == ($past(mem_rdata) == 8'h00))
    else $error("decrement result wrong");
  clear_mem_a: assert property ((s_q.state == S_EXEC && s_q.op == OP_CLEAR_M) |=>
    mem_wr && mem_wdata == 8'h00 && $stable(s_q.flags))
    else $error("clear wrote nonzero or moved flags");
  sub_borrow_a: assert property ((s_q.state == S_EXEC && s_q.op == OP_SUB_AM) |=>
    s_q.flags.c == ($past(s_q.work_register) < $past(mem_rdata)) &&
    s_q.flags.aux_carry_flag == ($past(s_q.work_register[3:0]) < $past(mem_rdata[3:0])))
    else $error("subtract borrow flags wrong");
  cmd_done_a: assert property (cmd_start |=> ##[1:5] idle)
    else $error("command did not finish");

  swap_seen_c: cover property (s_q.state == S_EXEC && s_q.op == OP_SWAP);
  pop_seen_c: cover property (s_q.state == S_POP_HI);
  sub_mem_c: cover property (s_q.state == S_EXEC && s_q.op == OP_SUBC_MA && s_q.flags.c);
endmodule
`default_nettype wire

// ---- inc/arith_stack_consts.svh ----
// Contract
// - exchange swaps memory and work register, flags kept
// - save writes both bytes, stack pointer plus two
// - restore lowers stack pointer two, then loads
// - add immediate updates work register, four flags
// - add memory to register or memory
// - add with carry, either destination
// - add carry alone to register or memory
// - negated add into register: memory minus register
// - negated add into memory: register minus memory
// - subtract immediate from work register, carry reports borrow
// - subtract memory from work register
// - subtract work register from memory, store memory
// - register minus memory minus carry, into register
// - memory minus register minus carry, into memory
// - subtract carry alone from register or memory
// - increment memory byte, four flags updated
// - decrement memory byte, four flags updated
// - clear memory byte, flags untouched
//
// offsets, field positions, reset values and widths of the datapath.
// assumes a 32-bit axi4-lite register bus and an 8-bit data memory.
`ifndef ARITH_STACK_CONSTS_SVH
`define ARITH_STACK_CONSTS_SVH

// ==========================================================
// register byte addresses
`define ADDR_CMD 32'h0000_0000
`define ADDR_WORK 32'h0000_0004
`define ADDR_FLAGS 32'h0000_0008
`define ADDR_STACK 32'h0000_000C
`define ADDR_STATUS 32'h0000_0010

// ==========================================================
// fields
`define CMD_OP_LSB 0
`define CMD_OP_MSB 4
`define CMD_ADDR_LSB 8
`define CMD_ADDR_MSB 15
`define CMD_IMM_LSB 16
`define CMD_IMM_MSB 23
`define FLAG_Z 0
`define FLAG_C 1
`define FLAG_AUX_CARRY 2
`define FLAG_OVERFLOW 3
`define STATUS_BUSY 0
`define OP_LAST 5'h15

// ==========================================================
// reset values and constants
`define RST_WORK 8'h00
`define RST_FLAGS 4'h0
`define RST_STACK 8'h00
`define STACK_STEP 8'h02
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- inc/arith_stack_pkg.sv ----
// types shared by the arithmetic and stack datapath.
// assumes arith_stack_consts.svh is on the include path.
`include "arith_stack_consts.svh"
`default_nettype none
package arith_stack_pkg;
  // ==========================================================
  // commands, in the order software encodes them (0 .. 21)
  typedef enum logic [4:0] {
    OP_SWAP, OP_SAVE, OP_RESTORE, OP_ADD_AI, OP_ADD_AM, OP_ADD_MA,
    OP_ADDC_AM, OP_ADDC_MA, OP_ADDC_A, OP_ADDC_M, OP_NADD_AM, OP_NADD_MA,
    OP_SUB_AI, OP_SUB_AM, OP_SUB_MA, OP_SUBC_AM, OP_SUBC_MA, OP_SUBC_A,
    OP_SUBC_M, OP_INC_M, OP_DEC_M, OP_CLEAR_M
  } op_e;

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT, S_EXEC, S_PUSH_HI, S_POP_WAIT, S_POP_HI
  } state_e;

  // ==========================================================
  // flag set, one packed state record
  typedef struct packed {
    logic overflow_flag;
    logic aux_carry_flag;
    logic c;
    logic z;
  } flags_s;

  typedef struct packed {
    state_e state;
    op_e op;
    logic [7:0] maddr;
    logic [7:0] imm;
    logic [7:0] work_register;
    flags_s flags;
    logic [7:0] stack_pointer;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic mem_rd;
    logic mem_wr;
    logic aw_held;
    logic [31:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;
endpackage
`default_nettype wire

// ---- tb/arith_mem_model.sv ----
// data memory model facing the datapath's memory port.
// assumes one clock; reads are synchronous and the byte holds until the next read.
`default_nettype none
module arith_mem_model (
  // clock
  input wire logic aclk,
  // memory port
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_rd,
  input wire logic mem_wr,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  // ========
  // storage
  // the bench preloads bytes directly; it only does so while the datapath is idle
  initial mem_rdata = 8'h00;
  always @(posedge aclk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      mem_rdata <= mem[mem_addr];
    end
  end
endmodule
`default_nettype wire

// ---- tb/arith_stack_datapath_tb.sv ----
// self-checking bench for the arithmetic and stack datapath.
// assumes the package, the design and the memory model are compiled first.
`include "arith_stack_consts.svh"
`default_nettype none
module arith_stack_datapath_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, mem_rd, mem_wr;
  logic [31:0] awaddr, wdata, araddr, rdata, last_rd;
  logic [3:0] wstrb, f;
  logic [1:0] bresp, rresp;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, a, m, im, ad, stk, w;
  logic [4:0] op;
  logic [20:0] ex;
  logic [34:0] re;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] mq[$];
  int err_count = 0;
  int n_tests = 0;
  integer seed = 32'h4e52;

  arith_stack_datapath DUT (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_rdata(mem_rdata)
  );

  arith_mem_model mem_i (
    .aclk(aclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_rdata(mem_rdata)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ========
  // checking
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic results();
    if (err_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // the watcher: every answer takes the oldest note and is compared unless that note marks it unchecked
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      re = rq.pop_front();
      if (re[34]) chk({rresp, rdata}, re[33:0]);
    end
    if (bvalid && bready) chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    // a memory write with no note pending is a stray write
    if (mem_wr) chk({18'h0, mem_addr, mem_wdata}, mq.size() ? {18'h0, mq.pop_front()} : 'x);
  end

  // ========
  // bus cycles
  task automatic wr(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= ad;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] ad, input logic [33:0] e, input bit u);
    rq.push_back({u, e});
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= ad;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    last_rd = rdata;
    rready <= 1'b0;
  endtask

  // issue a command, then poll busy; a write while busy would be dropped
  task automatic run(input logic [4:0] op, input logic [7:0] ad, input logic [7:0] im);
    wr(`ADDR_CMD, {8'h00, im, ad, 3'h0, op}, `RESP_OKAY);
    last_rd = 32'h0000_0001;
    for (int k = 0; k < 20 && last_rd[0]; k++) rd(`ADDR_STATUS, 34'h0, 1'b0);
    // a command that never finishes is a failure, not a reason to go on
    if (last_rd[0]) begin
      err_count++;
      results();
    end
  endtask

  // ========
  // reference arithmetic, result {overflow, aux carry, carry, zero, byte}
  function automatic logic [11:0] alu(input logic [7:0] x, input logic [7:0] y,
                                      input logic ci, input logic sb);
    logic [8:0] s;
    logic [4:0] h;
    if (sb) begin
      s = {1'b0, x} - {1'b0, y} - 9'(ci);
      h = {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(ci);
    end else begin
      s = {1'b0, x} + {1'b0, y} + 9'(ci);
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(ci);
    end
    return {(x[7] ^ s[7]) & (sb ^ ~(x[7] ^ y[7])), h[4], s[8], s[7:0] == 8'h00, s[7:0]};
  endfunction

  // returns {memory written, work, memory byte, flags}
  function automatic logic [20:0] ref_op(input logic [4:0] op, input logic [7:0] a,
                                         input logic [7:0] m, input logic [7:0] im,
                                         input logic [3:0] f);
    logic [7:0] x;
    logic [7:0] y;
    logic [11:0] r;
    x = (op inside {9, 10, 14, 16, 18, 19, 20}) ? m : a;
    y = (op inside {3, 12}) ? im : (op inside {8, 9, 17, 18}) ? 8'h00 :
        (op inside {19, 20}) ? 8'h01 : (op inside {10, 14, 16}) ? a : m;
    r = alu(x, y, f[1] && (op inside {[6:9], [15:18]}), op inside {[10:18], 20});
    if (op == 5'h00) return {1'b1, m, a, f};
    if (op == 5'h15) return {1'b1, a, 8'h00, f};
    if (op inside {5, 7, 9, 11, 14, 16, 18, 19, 20}) return {1'b1, a, r[7:0], r[11:8]};
    return {1'b0, r[7:0], m, r[11:8]};
  endfunction

  // ========
  // main sequence
  initial begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, then the unmapped word just past the map
    for (int k = 1; k < 6; k++) rd(32'(k * 4), {(k == 5) ? `RESP_SLVERR : `RESP_OKAY, 32'h0}, 1'b1);
    wr(32'h0000_0014, 32'h0000_00ff, `RESP_SLVERR);
    // save and restore round trip, stack pointer may wrap
    stk = 8'($random(seed));
    w = 8'($random(seed));
    f = 4'($random(seed));
    wr(`ADDR_STACK, {24'h0, stk}, `RESP_OKAY);
    wr(`ADDR_WORK, {24'h0, w}, `RESP_OKAY);
    wr(`ADDR_FLAGS, {28'h0, f}, `RESP_OKAY);
    mq.push_back({stk, w});
    mq.push_back({stk + 8'h01, 4'h0, f});
    run(5'h01, 8'h00, 8'h00);
    rd(`ADDR_STACK, {26'h0, stk + 8'h02}, 1'b1);
    rd(`ADDR_FLAGS, {30'h0, f}, 1'b1);
    wr(`ADDR_WORK, {24'h0, ~w}, `RESP_OKAY);
    wr(`ADDR_FLAGS, {28'h0, ~f}, `RESP_OKAY);
    run(5'h02, 8'h00, 8'h00);
    rd(`ADDR_STACK, {26'h0, stk}, 1'b1);
    rd(`ADDR_WORK, {26'h0, w}, 1'b1);
    rd(`ADDR_FLAGS, {30'h0, f}, 1'b1);
    // every arithmetic and exchange command, three rounds of random operands
    for (int i = 0; i < 66; i++) begin
      op = 5'(i % 22);
      if (op inside {5'h01, 5'h02}) continue;
      a = 8'($random(seed));
      m = 8'($random(seed));
      im = 8'($random(seed));
      ad = 8'($random(seed));
      f = 4'($random(seed));
      wr(`ADDR_WORK, {24'h0, a}, `RESP_OKAY);
      wr(`ADDR_FLAGS, {28'h0, f}, `RESP_OKAY);
      mem_i.mem[ad] = m;
      ex = ref_op(op, a, m, im, f);
      if (ex[20]) mq.push_back({ad, ex[11:4]});
      run(op, ad, im);
      rd(`ADDR_WORK, {26'h0, ex[19:12]}, 1'b1);
      rd(`ADDR_FLAGS, {30'h0, ex[3:0]}, 1'b1);
      chk({30'h0, last_rd[3:0]}, {30'h0, ex[3:0]});
    end
    // an opcode past the last one is dropped and starts nothing
    wr(`ADDR_CMD, 32'h0000_0016, `RESP_OKAY);
    rd(`ADDR_STATUS, 34'h0, 1'b1);
    // without the low strobes neither a register nor a command is taken
    wstrb <= 4'h8;
    wr(`ADDR_WORK, 32'h0000_00a5, `RESP_OKAY);
    wr(`ADDR_CMD, 32'h00ff_0003, `RESP_OKAY);
    wstrb <= 4'hf;
    rd(`ADDR_WORK, {26'h0, ex[19:12]}, 1'b1);
    // the latched command is still the last clear, so no later one was taken
    rd(`ADDR_CMD, {10'h000, im, ad, 3'h0, 5'h15}, 1'b1);
    repeat (4) @(posedge aclk);
    // every noted answer and memory write must have been seen
    chk(34'(mq.size() + bq.size() + rq.size()), 34'h0);
    results();
  end

  // hang guard, far beyond the fourteen hundred or so cycles the sequence needs
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    results();
  end
endmodule
`default_nettype wire
